// ==== hpc_pkg.sv ====
package hpc_pkg;
  // ****************************************************************
  // Control register layout
  // ****************************************************************
  localparam int          CTRL_W        = 16;
  localparam int          ADDR_W        = 20;
  localparam int          ADDR_LO_W     = 16;
  localparam int          ADDR_HI_W     = 4;
  localparam int          BIT_BOOT_DONE = 0;
  localparam int          BIT_IRQ       = 1;
  localparam int          BIT_UPPER_SEL = 5;
  localparam logic [15:0] CTRL_RESET    = 16'h0000;
  localparam logic [15:0] CTRL_RW_MASK  = 16'hfffc;
  localparam logic [1:0]  SEL_CTRL      = 2'h0;
  localparam logic [1:0]  SEL_ADDR      = 2'h2;
endpackage

// ==== hpc_sync.sv ====
`timescale 1ns/10ps
module hpc_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk,
  input  wire logic             resetn,
  input  wire logic [WIDTH-1:0] d,
  output logic      [WIDTH-1:0] q
);
  logic [WIDTH-1:0] meta_reg;

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      meta_reg <= '0;
      q        <= '0;
    end
    else
    begin
      meta_reg <= d;
      q        <= meta_reg;
    end
  end
endmodule

// ==== hpc_top.sv ====
`timescale 1ns/10ps
// How it works
// - Select bit clear: address-holding write loads bits 15-0 from all data lines.
// - Select bit set: address-holding write loads bits 19-16 from data lines 3-0.
// - Nonmultiplexed mode ignores select bit; address comes from address lines.
// - Writing 1 to interrupt bit sends maskable interrupt request to core.
// - Writing 0 to interrupt bit does nothing; bit always reads 0.
// - Boot-complete bit clears on DSP reset.
// - Core stalls in host boot while boot-complete is 0, runs once 1.
// - Bits 1,0 write-only; others read/write; all reset to zero.
// - Only the host reaches the control register; core has no path.
// - Each write of 1 gives exactly one request; no clearing needed.
module hpc_top (
  input  wire logic        CLK,
  input  wire logic        RESETN,
  input  wire logic        MUX_MODE,
  input  wire logic        HOST_WR_STB,
  input  wire logic        ACCESS_SELECT_HIGH,
  input  wire logic        ACCESS_SELECT_LOW,
  input  wire logic [15:0] HOST_DATA_LINES,
  input  wire logic [19:0] HOST_ADDRESS_LINES,
  input  wire logic        HOST_BOOT_MODE,
  output logic      [15:0] HOST_READ_DATA,
  output logic      [19:0] MEM_ADDRESS,
  output logic             HOST_TO_CORE_IRQ,
  output logic             BOOT_COMPLETE,
  output logic             CORE_STALL
);
  // ****************************************************************
  // Input synchronisers
  // ****************************************************************
  localparam int SW = 1 + 1 + 1 + 1 + hpc_pkg::CTRL_W + hpc_pkg::ADDR_W + 1;
  logic [SW-1:0] raw_in;
  logic [SW-1:0] sync_in;
  logic          mux_s;
  logic          stb_s;
  logic          sel_hi_s;
  logic          sel_lo_s;
  logic [hpc_pkg::CTRL_W-1:0] data_s;
  logic [hpc_pkg::ADDR_W-1:0] addr_s;
  logic          boot_mode_s;
  logic          stb_d_reg;
  logic          wr_pulse;
  logic          ctrl_wr;
  logic          addr_wr;

  assign raw_in = {MUX_MODE, HOST_WR_STB, ACCESS_SELECT_HIGH, ACCESS_SELECT_LOW,
                   HOST_DATA_LINES, HOST_ADDRESS_LINES, HOST_BOOT_MODE};

  hpc_sync #(.WIDTH(SW)) u_sync (
    .clk    (CLK),
    .resetn (RESETN),
    .d      (raw_in),
    .q      (sync_in)
  );

  assign {mux_s, stb_s, sel_hi_s, sel_lo_s, data_s, addr_s, boot_mode_s} = sync_in;

  always_ff @(posedge CLK or negedge RESETN)
  begin
    if (!RESETN)
      stb_d_reg <= 1'b0;
    else
      stb_d_reg <= stb_s;
  end

  // Write taken on the rising edge of the synchronised strobe
  assign wr_pulse = stb_s & ~stb_d_reg;

  function automatic logic is_ctrl(input logic mux, input logic hi, input logic lo);
    is_ctrl = mux ? ({hi, lo} == hpc_pkg::SEL_CTRL) : ~lo;
  endfunction

  // only host-side decode reaches the register
  assign ctrl_wr = wr_pulse & is_ctrl(mux_s, sel_hi_s, sel_lo_s);
  assign addr_wr = wr_pulse & mux_s & ({sel_hi_s, sel_lo_s} == hpc_pkg::SEL_ADDR);

  // ****************************************************************
  // Control register
  // ****************************************************************
  logic [hpc_pkg::CTRL_W-1:0] ctrl_reg;
  logic                       irq_reg;
  logic                       boot_reg;
  logic [hpc_pkg::ADDR_W-1:0] hold_reg;
  logic [hpc_pkg::ADDR_W-1:0] mem_addr_reg;

  always_ff @(posedge CLK or negedge RESETN)
  begin
    if (!RESETN)
      ctrl_reg <= hpc_pkg::CTRL_RESET;
    else if (ctrl_wr)
      ctrl_reg <= data_s & hpc_pkg::CTRL_RW_MASK;
  end

  // One request per write of 1; the bit itself is never stored
  always_ff @(posedge CLK or negedge RESETN)
  begin
    if (!RESETN)
      irq_reg <= 1'b0;
    else
      irq_reg <= ctrl_wr & data_s[hpc_pkg::BIT_IRQ];
  end

  // Boot-complete is sticky until the next reset
  always_ff @(posedge CLK or negedge RESETN)
  begin
    if (!RESETN)
      boot_reg <= 1'b0;
    else if (ctrl_wr && data_s[hpc_pkg::BIT_BOOT_DONE])
      boot_reg <= 1'b1;
  end

  // ****************************************************************
  // Address holding register
  // ****************************************************************
  always_ff @(posedge CLK or negedge RESETN)
  begin
    if (!RESETN)
      hold_reg <= '0;
    else if (addr_wr)
    begin
      if (ctrl_reg[hpc_pkg::BIT_UPPER_SEL])
        hold_reg[hpc_pkg::ADDR_W-1:hpc_pkg::ADDR_LO_W] <= data_s[hpc_pkg::ADDR_HI_W-1:0];
      else
        hold_reg[hpc_pkg::ADDR_LO_W-1:0] <= data_s;
    end
  end

  // ****************************************************************
  // Memory address output
  // ****************************************************************
  // Registered so the core sees a clean address after a mode change
  always_ff @(posedge CLK or negedge RESETN)
  begin
    if (!RESETN)
      mem_addr_reg <= '0;
    else if (mux_s)
      mem_addr_reg <= hold_reg;
    else
      mem_addr_reg <= addr_s;
  end

  assign HOST_READ_DATA   = ctrl_reg;
  assign MEM_ADDRESS      = mem_addr_reg;
  assign HOST_TO_CORE_IRQ = irq_reg;
  assign BOOT_COMPLETE    = boot_reg;
  assign CORE_STALL       = boot_mode_s & ~boot_reg;

  // ****************************************************************
  // Checks
  // ****************************************************************
  sequence s_irq_write;
    ctrl_wr && data_s[hpc_pkg::BIT_IRQ];
  endsequence

  sequence s_boot_write;
    ctrl_wr && data_s[hpc_pkg::BIT_BOOT_DONE];
  endsequence

  sequence s_load_hi;
    addr_wr && ctrl_reg[hpc_pkg::BIT_UPPER_SEL];
  endsequence

  sequence s_load_lo;
    addr_wr && !ctrl_reg[hpc_pkg::BIT_UPPER_SEL];
  endsequence

  // Interrupt request
  AST_IRQ_PULSE: assert property (@(posedge CLK) disable iff (!RESETN)
    s_irq_write |=> HOST_TO_CORE_IRQ ##1 !HOST_TO_CORE_IRQ)
    else $error("interrupt request not a single pulse");
  AST_IRQ_CAUSE: assert property (@(posedge CLK) disable iff (!RESETN)
    HOST_TO_CORE_IRQ |-> $past(ctrl_wr) && $past(data_s[hpc_pkg::BIT_IRQ]))
    else $error("interrupt without a write of one");
  AST_IRQ_ZERO: assert property (@(posedge CLK) disable iff (!RESETN)
    (ctrl_wr && !data_s[hpc_pkg::BIT_IRQ]) |=> !HOST_TO_CORE_IRQ)
    else $error("write of zero raised an interrupt request");
  AST_IRQ_READ0: assert property (@(posedge CLK) disable iff (!RESETN)
    HOST_READ_DATA[hpc_pkg::BIT_IRQ:hpc_pkg::BIT_BOOT_DONE] == 2'h0)
    else $error("write-only bits read nonzero");

  // Boot handshake
  AST_BOOT_STICKY: assert property (@(posedge CLK) disable iff (!RESETN)
    BOOT_COMPLETE |=> BOOT_COMPLETE)
    else $error("boot-complete dropped without reset");
  AST_BOOT_SET: assert property (@(posedge CLK) disable iff (!RESETN)
    s_boot_write |=> BOOT_COMPLETE && !CORE_STALL)
    else $error("core still stalled after boot-complete");
  AST_BOOT_HOLD: assert property (@(posedge CLK) disable iff (!RESETN)
    (!BOOT_COMPLETE && !(ctrl_wr && data_s[hpc_pkg::BIT_BOOT_DONE])) |=> !BOOT_COMPLETE)
    else $error("boot-complete set without a host write");

  // Address path
  AST_ADDR_LO: assert property (@(posedge CLK) disable iff (!RESETN)
    s_load_lo |=> hold_reg[hpc_pkg::ADDR_LO_W-1:0] == $past(data_s))
    else $error("low address not loaded");
  AST_ADDR_HI: assert property (@(posedge CLK) disable iff (!RESETN)
    s_load_hi |=> hold_reg[hpc_pkg::ADDR_W-1:hpc_pkg::ADDR_LO_W]
      == $past(data_s[hpc_pkg::ADDR_HI_W-1:0])
      && $stable(hold_reg[hpc_pkg::ADDR_LO_W-1:0]))
    else $error("upper address not loaded");
  AST_NONMUX: assert property (@(posedge CLK) disable iff (!RESETN)
    !mux_s |=> MEM_ADDRESS == $past(addr_s))
    else $error("nonmultiplexed address not from address lines");
  AST_NONMUX_HOLD: assert property (@(posedge CLK) disable iff (!RESETN)
    (wr_pulse && !mux_s) |=> $stable(hold_reg))
    else $error("address holding register loaded in nonmultiplexed mode");
  AST_MUX_ADDR: assert property (@(posedge CLK) disable iff (!RESETN)
    mux_s |=> MEM_ADDRESS == $past(hold_reg))
    else $error("multiplexed address not from holding register");

  // Register contents
  AST_SEL_READ: assert property (@(posedge CLK) disable iff (!RESETN)
    ctrl_wr |=> HOST_READ_DATA[hpc_pkg::BIT_UPPER_SEL] == $past(data_s[hpc_pkg::BIT_UPPER_SEL]))
    else $error("select bit readback wrong");
  AST_CTRL_HOLD: assert property (@(posedge CLK) disable iff (!RESETN)
    !ctrl_wr |=> $stable(HOST_READ_DATA))
    else $error("control register changed without a host write");
  AST_RESET_CLEAR: assert property (@(posedge CLK) disable iff (!RESETN)
    $rose(RESETN) |-> HOST_READ_DATA == hpc_pkg::CTRL_RESET && !BOOT_COMPLETE
      && !HOST_TO_CORE_IRQ && MEM_ADDRESS == '0)
    else $error("register not at reset value after reset");
endmodule

// ==== hpc_host.sv ====
`timescale 1ns/10ps
module hpc_host (
  input  wire logic        clk,
  output logic             wr_stb,
  output logic             sel_hi,
  output logic             sel_lo,
  output logic      [15:0] data
);
  logic upper_reg;
  initial
  begin
    {wr_stb, sel_hi, sel_lo, data, upper_reg} = '0;
  end
  // Selects and data settle 3 cycles before the strobe
  task automatic put(input logic [1:0] sel, input logic [15:0] d);
    logic [15:0] v;
    begin
      v = (sel == hpc_pkg::SEL_CTRL) ? (d & 16'h0023) : d;
      if (sel == hpc_pkg::SEL_ADDR && upper_reg)
        v = v & 16'h000f;
      if (sel == hpc_pkg::SEL_CTRL)
        upper_reg = v[5];
      @(posedge clk);
      {sel_hi, sel_lo} <= sel;
      data <= v;
      repeat (3) @(posedge clk);
      wr_stb <= 1'b1;
      repeat (4) @(posedge clk);
      wr_stb <= 1'b0;
      repeat (4) @(posedge clk);
      data <= ~v;
    end
  endtask
endmodule

// ==== test_host_port_control_register.sv ====
`timescale 1ns/10ps
module test_host_port_control_register;
  logic        clk, resetn, mux, bmode, wr, sh, sl, irq, boot, stall;
  logic [15:0] hd, rd, lo, hi, ex_c;
  logic [19:0] ha, ma, ex_a;
  logic [45:0] notes[$], n;
  int          err_count, total_checks, seed, irq_cnt, ex_i, k;
  event        done;
  hpc_top u_hpc_top (.CLK(clk), .RESETN(resetn), .MUX_MODE(mux), .HOST_WR_STB(wr),
    .ACCESS_SELECT_HIGH(sh), .ACCESS_SELECT_LOW(sl), .HOST_DATA_LINES(hd),
    .HOST_ADDRESS_LINES(ha), .HOST_BOOT_MODE(bmode), .HOST_READ_DATA(rd),
    .MEM_ADDRESS(ma), .HOST_TO_CORE_IRQ(irq), .BOOT_COMPLETE(boot), .CORE_STALL(stall));
  hpc_host u_hpc_host (.clk(clk), .wr_stb(wr), .sel_hi(sh), .sel_lo(sl), .data(hd));
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  always @(posedge clk)
    if (irq === 1'b1)
      irq_cnt++;
  task check(input logic [45:0] seen, input logic [45:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      err_count++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task summarize;
    if (err_count == 0 && total_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task note(input logic b, input logic s);
    #1;
    notes.push_back({ex_c, ex_a, ex_i[7:0], b, s});
    ->done;
  endtask
  // Each note is taken off in order once the outputs have settled
  always @(done)
  begin
    n = notes.pop_front();
    check({rd & 16'h0023, ma, irq_cnt[7:0], boot, stall}, n);
  end
  initial
  begin
    {resetn, ha, irq_cnt, err_count, total_checks, ex_i, ex_a, ex_c} = '0;
    {mux, bmode} = 2'b11;
    seed = 47;
    repeat (5) @(posedge clk);
    resetn <= 1'b1;
    repeat (4) @(posedge clk);
    note(1'b0, 1'b1);
    hi = 16'($random(seed));
    lo = 16'($random(seed));
    u_hpc_host.put(hpc_pkg::SEL_CTRL, 16'h0020);
    ex_c = 16'h0020;
    note(1'b0, 1'b1);
    u_hpc_host.put(hpc_pkg::SEL_ADDR, hi);
    u_hpc_host.put(hpc_pkg::SEL_CTRL, 16'h0000);
    u_hpc_host.put(hpc_pkg::SEL_ADDR, lo);
    {ex_c, ex_a} = {16'h0000, hi[3:0], lo};
    note(1'b0, 1'b1);
    u_hpc_host.put(2'h1, 16'h0022);
    u_hpc_host.put(hpc_pkg::SEL_CTRL, 16'h0002);
    u_hpc_host.put(hpc_pkg::SEL_CTRL, 16'h0000);
    ex_i = 1;
    note(1'b0, 1'b1);
    u_hpc_host.put(hpc_pkg::SEL_CTRL, 16'h0003);
    ex_i = 2;
    k = 0;
    while (boot !== 1'b1 && k < 20)
    begin
      @(posedge clk);
      k++;
    end
    if (k == 20)
      err_count++;
    else
    begin
      note(1'b1, 1'b0);
      @(posedge clk);
      mux <= 1'b0;
      ha  <= 20'($random(seed));
      u_hpc_host.put(2'h1, 16'h1234);
      ex_a = ha;
      note(1'b1, 1'b0);
      u_hpc_host.put(hpc_pkg::SEL_CTRL, 16'h0020);
      ex_c = 16'h0020;
      note(1'b1, 1'b0);
      @(posedge clk);
      mux    <= 1'b1;
      resetn <= 1'b0;
      repeat (2) @(posedge clk);
      resetn <= 1'b1;
      repeat (5) @(posedge clk);
      {ex_c, ex_a} = '0;
      note(1'b0, 1'b1);
    end
    #10;
    summarize();
  end
endmodule
